/* File: rtl/low_power_mode_control_defs.vh */
`ifndef LOW_POWER_MODE_CONTROL_DEFS_VH
`define LOW_POWER_MODE_CONTROL_DEFS_VH

// Power mode state codes
`define LPM_ST_RUN        3'h0
`define LPM_ST_WAIT       3'h1
`define LPM_ST_ACT_HALT   3'h2
`define LPM_ST_HALT       3'h3
`define LPM_ST_STARTUP    3'h4
`define LPM_ST_WAKE       3'h5

// Wake cause codes
`define LPM_CAUSE_NONE    2'h0
`define LPM_CAUSE_IRQ     2'h1
`define LPM_CAUSE_RESET   2'h2

// Start-up delay after a halt exit, in CPU cycles
`define LPM_STARTUP_CYCLES 4096

`endif

/* File: rtl/low_power_mode_control.v */
// Operation
// RULE1 - A wait instruction stops the CPU while all peripherals keep running and clocked.
// RULE2 - Entering wait clears the interrupt mask and leaves all other state untouched.
// RULE3 - Wait lasts until an interrupt or reset, then the matching service routine is fetched.
// RULE4 - Servicing pushes the condition codes, sets the mask, and the pop restores it clear.
// RULE5 - On a halt instruction the timebase enable picks full halt (0) or active halt (1).
// RULE6 - Active halt ends on the timebase interrupt, a wake-capable interrupt or a reset.
// RULE7 - Any wake from active halt waits 4096 CPU cycles before servicing or vector fetch.
// RULE8 - Entering either halt clears the mask, and a pending interrupt wakes at once.
// RULE9 - In active halt only the oscillator and timebase counter run; others lose clock.
// RULE10 - With the timebase enable set, active halt with the watchdog running gives no reset.
// RULE11 - Full halt ends on a wake-capable interrupt or reset, restarting the oscillator for 4096 cycles.
// RULE12 - Entering full halt forces the interrupt mask to zero so a pending interrupt wakes at once.
// RULE13 - Full halt stops the oscillator and all processing except externally clocked peripherals.
// RULE14 - A watchdog stop option decides whether a halt with the watchdog on resets the device.
// RULE15 - Timebase and clock security interrupts wake only from active halt, never full halt.
// RULE16 - Entering wait while in slow mode gives a combined slow-wait state.
// RULE17 - Waking from wait resumes with no oscillator stabilisation delay.
`timescale 1ns/10ps
`default_nettype none
`include "low_power_mode_control_defs.vh"

module low_power_mode_control #(
  parameter STARTUP_CYCLES = `LPM_STARTUP_CYCLES
) (
  input  wire       ref_clk_i,
  input  wire       reset_i,
  input  wire       clk_en_i,
  input  wire       wait_for_interrupt_instr_i,
  input  wire       halt_instr_i,
  input  wire       timebase_irq_enable_i,
  input  wire       slow_mode_i,
  input  wire       watchdog_active_i,
  input  wire       watchdog_stop_option_i,
  input  wire       any_irq_i,
  input  wire       halt_wake_irq_i,
  input  wire       timebase_irq_i,
  input  wire       clock_security_irq_i,
  input  wire       wake_reset_i,
  input  wire       irq_entry_i,
  input  wire       irq_return_i,
  output reg        cpu_clk_en_o,
  output reg        periph_clk_en_o,
  output reg        osc_en_o,
  output reg        timebase_clk_en_o,
  output reg        irq_mask_o,
  output reg        push_cc_o,
  output reg        service_irq_o,
  output reg        fetch_reset_vector_o,
  output reg        watchdog_reset_o,
  output reg        slow_wait_o,
  output reg  [2:0] mode_o
);

  // Counter width covers the documented start-up delay with room to spare
  localparam CNT_W = 13;
  // Last count value, kept at integer width so no bits are dropped
  localparam integer START_LAST = STARTUP_CYCLES - 1;
  // Counter widened to integer width for the end-of-delay compare
  wire [31:0] cnt_wide = {{(32-CNT_W){1'b0}}, cnt_q};

  reg [2:0]       state_q;
  reg [2:0]       state_d;
  reg [1:0]       cause_q;
  reg [1:0]       cause_d;
  reg [CNT_W-1:0] cnt_q;
  reg [CNT_W-1:0] cnt_d;
  reg             mask_q;
  reg             mask_d;
  reg             slow_wait_d;
  reg             wdg_rst_d;

  // Timebase and clock security sources are wake-capable in active halt only
  // A full halt has no timebase running, so those sources cannot be trusted there
  // RULE15 - source gating
  wire act_wake = halt_wake_irq_i | timebase_irq_i | clock_security_irq_i;
  wire full_wake = halt_wake_irq_i;

  // Next-state logic for the mode sequencer
  always @* begin
    state_d     = state_q;
    cause_d     = cause_q;
    cnt_d       = cnt_q;
    mask_d      = mask_q;
    slow_wait_d = slow_wait_o;
    wdg_rst_d   = 1'b0;
    case (state_q)
      `LPM_ST_RUN: begin
        // RULE4 - mask set on entry
        if (irq_entry_i) begin
          mask_d = 1'b1;
        end else if (irq_return_i) begin
          mask_d = 1'b0;
        end
        if (wait_for_interrupt_instr_i) begin
          // RULE2 - clear mask on wait
          mask_d = 1'b0;
          // RULE16 - slow wait combine
          slow_wait_d = slow_mode_i;
          // RULE1 - stop CPU only
          state_d = `LPM_ST_WAIT;
        end else if (halt_instr_i) begin
          // RULE8 - clear mask on halt
          // RULE12 - force mask zero
          mask_d = 1'b0;
          if (any_irq_i) begin
            // Pending interrupt wakes straight away
            cause_d = `LPM_CAUSE_IRQ;
            cnt_d   = {CNT_W{1'b0}};
            state_d = `LPM_ST_STARTUP;
          // RULE5 - timebase enable selects
          end else if (timebase_irq_enable_i) begin
            // RULE10 - no watchdog reset
            state_d = `LPM_ST_ACT_HALT;
          end else if (watchdog_active_i && !watchdog_stop_option_i) begin
            // RULE14 - option gated reset
            wdg_rst_d = 1'b1;
          end else begin
            state_d = `LPM_ST_HALT;
          end
        end
      end
      `LPM_ST_WAIT: begin
        // RULE3 - wake on irq/reset
        // RULE17 - no start-up delay
        if (wake_reset_i || any_irq_i) begin
          cause_d     = wake_reset_i ? `LPM_CAUSE_RESET : `LPM_CAUSE_IRQ;
          slow_wait_d = 1'b0;
          state_d     = `LPM_ST_WAKE;
        end
      end
      `LPM_ST_ACT_HALT: begin
        // RULE6 - active halt exits
        if (wake_reset_i || act_wake) begin
          cause_d = wake_reset_i ? `LPM_CAUSE_RESET : `LPM_CAUSE_IRQ;
          cnt_d   = {CNT_W{1'b0}};
          state_d = `LPM_ST_STARTUP;
        end
      end
      `LPM_ST_HALT: begin
        // RULE11 - full halt exits
        if (wake_reset_i || full_wake) begin
          cause_d = wake_reset_i ? `LPM_CAUSE_RESET : `LPM_CAUSE_IRQ;
          cnt_d   = {CNT_W{1'b0}};
          state_d = `LPM_ST_STARTUP;
        end
      end
      `LPM_ST_STARTUP: begin
        // RULE7 - 4096 cycle delay
        if (cnt_wide == START_LAST) begin
          state_d = `LPM_ST_WAKE;
        end else begin
          cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
      `LPM_ST_WAKE: begin
        // RULE4 - mask set for routine
        if (cause_q == `LPM_CAUSE_IRQ) begin
          mask_d = 1'b1;
        end
        cause_d = `LPM_CAUSE_NONE;
        state_d = `LPM_ST_RUN;
      end
      default: begin
        state_d = `LPM_ST_RUN;
      end
    endcase
  end

  // State registers, frozen while the clock enable is low
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q          <= `LPM_ST_RUN;
      cause_q          <= `LPM_CAUSE_NONE;
      cnt_q            <= {CNT_W{1'b0}};
      mask_q           <= 1'b1;
      slow_wait_o      <= 1'b0;
      watchdog_reset_o <= 1'b0;
    end else if (clk_en_i) begin
      state_q          <= state_d;
      cause_q          <= cause_d;
      cnt_q            <= cnt_d;
      mask_q           <= mask_d;
      slow_wait_o      <= slow_wait_d;
      watchdog_reset_o <= wdg_rst_d;
    end
  end

  // Registered outputs derived from the next state
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cpu_clk_en_o         <= 1'b1;
      periph_clk_en_o      <= 1'b1;
      osc_en_o             <= 1'b1;
      timebase_clk_en_o    <= 1'b1;
      irq_mask_o           <= 1'b1;
      push_cc_o            <= 1'b0;
      service_irq_o        <= 1'b0;
      fetch_reset_vector_o <= 1'b0;
      mode_o               <= `LPM_ST_RUN;
    end else if (clk_en_i) begin
      cpu_clk_en_o         <= (state_d == `LPM_ST_RUN) || (state_d == `LPM_ST_WAKE);
      // RULE1 - peripherals run in wait
      // RULE9 - only timebase in active halt
      periph_clk_en_o      <= (state_d == `LPM_ST_RUN) || (state_d == `LPM_ST_WAIT) ||
                              (state_d == `LPM_ST_WAKE);
      // RULE13 - oscillator off in halt
      osc_en_o             <= (state_d != `LPM_ST_HALT);
      timebase_clk_en_o    <= (state_d != `LPM_ST_HALT);
      // RULE4 - mask set with service
      // Mask shows set from the service cycle on, ahead of the held copy
      irq_mask_o           <= mask_d | ((state_d == `LPM_ST_WAKE) && (cause_d == `LPM_CAUSE_IRQ));
      // RULE4 - push condition codes
      push_cc_o            <= (state_d == `LPM_ST_WAKE) && (cause_d == `LPM_CAUSE_IRQ);
      // RULE3 - vector selection
      service_irq_o        <= (state_d == `LPM_ST_WAKE) && (cause_d == `LPM_CAUSE_IRQ);
      fetch_reset_vector_o <= (state_d == `LPM_ST_WAKE) && (cause_d == `LPM_CAUSE_RESET);
      mode_o               <= state_d;
    end
  end

endmodule
`default_nettype wire

/* File: verif/low_power_mode_control_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module low_power_mode_control_properties #(parameter STARTUP_CYCLES = 4096) (
  input wire logic       ref_clk_i,
  input wire logic       reset_i,
  input wire logic       clk_en_i,
  input wire logic       wait_for_interrupt_instr_i,
  input wire logic       halt_instr_i,
  input wire logic       timebase_irq_enable_i,
  input wire logic       watchdog_active_i,
  input wire logic       watchdog_stop_option_i,
  input wire logic       any_irq_i,
  input wire logic       halt_wake_irq_i,
  input wire logic       wake_reset_i,
  input wire logic       cpu_clk_en_o,
  input wire logic       periph_clk_en_o,
  input wire logic       osc_en_o,
  input wire logic       timebase_clk_en_o,
  input wire logic       irq_mask_o,
  input wire logic       push_cc_o,
  input wire logic       service_irq_o,
  input wire logic       watchdog_reset_o,
  input wire logic [2:0] mode_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // Halt taken in run, and the watchdog refusal condition
  wire logic go  = clk_en_i && mode_o == 3'h0 && halt_instr_i && !wait_for_interrupt_instr_i;
  wire logic refuse = watchdog_active_i && !watchdog_stop_option_i && !timebase_irq_enable_i;
  logic [31:0] stay_q;
  // Counts cycles spent in start-up
  always @(posedge ref_clk_i or posedge reset_i)
    if (reset_i) stay_q <= 32'h0;
    else if (clk_en_i) stay_q <= (mode_o == 3'h4) ? stay_q + 32'h1 : 32'h0;
  a_wait_entry: assert property (clk_en_i && mode_o == 3'h0 && wait_for_interrupt_instr_i
    |=> mode_o == 3'h1 && !irq_mask_o) else $error("wait entry");
  a_halt_select: assert property (go && !refuse && !any_irq_i
    |=> mode_o == ($past(timebase_irq_enable_i) ? 3'h2 : 3'h3) && !irq_mask_o) else $error("halt");
  a_pending_wake: assert property (go && !refuse && any_irq_i |=> mode_o == 3'h4)
    else $error("pending");
  a_watchdog_refuse: assert property (go && refuse && !any_irq_i
    |=> watchdog_reset_o && mode_o == 3'h0) else $error("refuse");
  a_wait_clocks: assert property (mode_o == 3'h1 |-> periph_clk_en_o && !cpu_clk_en_o)
    else $error("wait clocks");
  a_active_clocks: assert property (mode_o == 3'h2
    |-> osc_en_o && timebase_clk_en_o && !periph_clk_en_o) else $error("active clocks");
  a_halt_clocks: assert property (mode_o == 3'h3 |-> !osc_en_o && !periph_clk_en_o)
    else $error("halt clocks");
  a_wait_prompt: assert property (clk_en_i && mode_o == 3'h1 && any_irq_i && !wake_reset_i
    |=> mode_o == 3'h5 && service_irq_o && push_cc_o) else $error("wait wake");
  a_halt_stays: assert property (clk_en_i && mode_o == 3'h3 && !halt_wake_irq_i
    && !wake_reset_i |=> mode_o == 3'h3) else $error("halt left");
  a_startup_len: assert property (mode_o == 3'h5 && stay_q != 0
    |-> stay_q == STARTUP_CYCLES) else $error("startup length");
endmodule
bind low_power_mode_control low_power_mode_control_properties
  #(.STARTUP_CYCLES(STARTUP_CYCLES)) props (.*);
`default_nettype wire

/* File: verif/cpu_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
module cpu_core_model (
  input  wire logic       clk_i,
  input  wire logic       service_i,
  input  wire logic [3:0] delay_i,
  output var logic        irq_return_o
);
  initial begin
    irq_return_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (service_i) begin
        repeat (int'(delay_i) + 1) @(posedge clk_i);
        irq_return_o <= 1'b1;
        @(posedge clk_i) irq_return_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verif/low_power_mode_control_test.sv */
`timescale 1ns/10ps
`default_nettype none
module low_power_mode_control_test;
  localparam int SC = 8;
  logic clk = 0, rst = 1, wait_for_interrupt_instr = 0, hlt = 0, tbe = 0, slow = 0, wd = 0, opt = 0, irq = 0, ret;
  logic ent = 0;
  logic [3:0] wk = 0, dly = 0; // Wake: reset, clock security, timebase, wake irq
  wire cpu, per, osc, tbc, mask, push, serv, fetch, wdr, sw;
  wire [2:0] mode;
  integer failures = 0, n_compared = 0, seed = 32'h12456938, cyc = 0, n, k;
  low_power_mode_control #(.STARTUP_CYCLES(SC)) dut (.ref_clk_i(clk), .reset_i(rst),
    .clk_en_i(1'b1), .wait_for_interrupt_instr_i(wait_for_interrupt_instr), .halt_instr_i(hlt),
    .timebase_irq_enable_i(tbe), .slow_mode_i(slow), .watchdog_active_i(wd),
    .watchdog_stop_option_i(opt), .any_irq_i(irq), .halt_wake_irq_i(wk[0]),
    .timebase_irq_i(wk[1]), .clock_security_irq_i(wk[2]), .wake_reset_i(wk[3]),
    .irq_entry_i(ent), .irq_return_i(ret), .cpu_clk_en_o(cpu), .periph_clk_en_o(per),
    .osc_en_o(osc), .timebase_clk_en_o(tbc), .irq_mask_o(mask), .push_cc_o(push),
    .service_irq_o(serv), .fetch_reset_vector_o(fetch), .watchdog_reset_o(wdr),
    .slow_wait_o(sw), .mode_o(mode));
  cpu_core_model core (.clk_i(clk), .service_i(serv), .delay_i(dly), .irq_return_o(ret));
  // Clock and hang limit
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) if (++cyc == 5000) begin failures++; conclude; end
  task automatic chk(input string s, input logic [7:0] e, g);
    n_compared++;
    if (g !== e) begin failures++; $display("mismatch %s expected %0h seen %0h", s, e, g); end
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Enter a mode, check it, wake it and check the exit sequence
  task automatic go(input logic w, h, te, input int em, input logic [3:0] v, input logic a,
                    input int len, input logic [2:0] p);
    @(posedge clk) {wait_for_interrupt_instr, hlt, tbe, slow, dly} <= {w, h, te, 1'($random(seed)), 4'($random(seed))};
    if (em == 4) irq <= 1;
    @(posedge clk) {wait_for_interrupt_instr, hlt} <= 2'h0;
    #1 chk("mode", em, mode);
    chk("wdog", em == 0, wdr);
    chk("slowwait", w & slow, sw);
    if (em != 4) chk("clocks", em == 1 ? 4'h7 : em == 2 ? 4'h3 : em == 3 ? 4'h0 : 4'hF,
      {cpu, per, osc, tbc});
    if (em != 0) begin
      if (em != 4) chk("mask", 0, mask);
      if (em == 3) begin
        @(posedge clk) wk <= 4'h6;
        @(posedge clk) wk <= 4'h0;
        #1 chk("mode", 3, mode);
      end
      if (em != 4) begin
        repeat (1 + ($random(seed) & 3)) @(posedge clk);
        {wk, irq} <= {v, a};
        @(posedge clk) #1;
      end
      for (n = 0; mode === 3'h4 && n < 99; n++) @(posedge clk) #1;
      chk("startup", len, n);
      chk("wake", 5, mode);
      chk("pulses", p, {push, serv, fetch});
      if (p[1]) chk("mask", 1, mask);
      @(posedge clk) {wk, irq} <= 5'h0;
      repeat (20) @(posedge clk);
      #1 chk("mode", 0, mode);
      if (p[1]) chk("mask", 0, mask);
    end
    $display("case for mode %0d done", em);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    #1 chk("mode", 0, mode);
    chk("mask", 1, mask);
    go(1, 0, 0, 1, 4'h0, 1, 0, 3'h6);
    go(1, 0, 0, 1, 4'h8, 0, 0, 3'h1);
    @(posedge clk) wd <= 1;
    for (k = 0; k < 4; k++) go(0, 1, 1, 2, 4'h1 << k, 0, SC, k == 3 ? 3'h1 : 3'h6);
    go(0, 1, 0, 0, 4'h0, 0, 0, 3'h0);
    @(posedge clk) opt <= 1;
    go(0, 1, 0, 3, 4'h1, 0, SC, 3'h6);
    go(0, 1, 0, 3, 4'h8, 0, SC, 3'h1);
    go(0, 1, 0, 4, 4'h0, 0, SC, 3'h6);
    go(0, 1, 1, 4, 4'h0, 0, SC, 3'h6);
    // Routine entry from run sets the mask
    @(posedge clk) ent <= 1;
    @(posedge clk) ent <= 0;
    #1 chk("entrymask", 1, mask);
    $display("case for routine entry done");
    conclude;
  end
endmodule
`default_nettype wire
